// file: ocs_chk_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// clock select port checker
// ----------------------------------------
module ocs_chk (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic fast_internal_rc,
   input wire logic low_power_internal_rc,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_tick,
   input wire logic instr_tick,
   input wire logic wdt_ref_clk,
   input wire logic [2:0] osc_mode,
   input wire logic pll_lock
);
   logic [3:0] up_reg; // cycles since reset, saturating
   logic [3:0] up_next;
   logic mapped; // address hits a register
   assign mapped = (paddr == 8'h00) || (paddr == 8'h04) || (paddr == 8'h08);
   // count up so that the strap cycles are skipped
   always_comb begin
      up_next = (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_reg <= 4'h0;
      end else begin
         up_reg <= up_next;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   apb_ready_a: assert property (psel && !penable |=> pready) else $error("ready missing");
   ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
   unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr && pready)
      else $error("unmapped not refused");
   mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr) else $error("mapped refused");
   wdt_ref_a: assert property ($past(arst_n) |-> wdt_ref_clk == $past(low_power_internal_rc))
      else $error("watchdog reference wrong");
   instr_half_a: assert property (instr_tick |-> osc_tick) else $error("lone instruction tick");
   frc_tick_a: assert property (up_reg > 4'h8 && osc_mode == 3'h0 && $rose(fast_internal_rc) |-> ##[1:2] osc_tick)
      else $error("fast rc tick missing");
   low_power_internal_rc_tick_a: assert property (up_reg > 4'h8 && osc_mode == 3'h5 && $rose(low_power_internal_rc) |-> ##[1:2] osc_tick)
      else $error("low power rc tick missing");
   pll_hold_a: assert property ((osc_mode == 3'h1 || osc_mode == 3'h3) && !pll_lock && !$past(pll_lock) |-> !osc_tick)
      else $error("pll tick before lock");
   mode_hold_a: assert property ($past(arst_n, 2) |-> $stable(osc_mode)) else $error("mode changed");
endmodule // ocs_chk

// file: ocs_osc_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// free running oscillator sources
// ----------------------------------------
module ocs_osc_src #(
   parameter int FRC_H = 100, // half periods in ns
   parameter int PRI_H = 140,
   parameter int SEC_H = 300,
   parameter int LOW_POWER_INTERNAL_RC_H = 500
) (
   output logic fast_internal_rc,
   output logic primary_osc_in,
   output logic secondary_osc_in,
   output logic low_power_internal_rc
);
   // crystals and rc cells run free, off the core clock edges
   initial begin
      fast_internal_rc = 1'b0;
      #3;
      forever #(FRC_H) fast_internal_rc = ~fast_internal_rc;
   end
   initial begin
      primary_osc_in = 1'b0;
      #7;
      forever #(PRI_H) primary_osc_in = ~primary_osc_in;
   end
   initial begin
      secondary_osc_in = 1'b0;
      #5;
      forever #(SEC_H) secondary_osc_in = ~secondary_osc_in;
   end
   initial begin
      low_power_internal_rc = 1'b0;
      #4;
      forever #(LOW_POWER_INTERNAL_RC_H) low_power_internal_rc = ~low_power_internal_rc;
   end
endmodule // ocs_osc_src

// file: ocs_pkg.sv
// ----------------------------------------
// oscillator select package
// ----------------------------------------
package ocs_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CLOCK_DIVISOR_REG = 8'h00;
   localparam logic [7:0] OFS_PLL_FEEDBACK_REG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   // clock divisor field positions
   localparam int FRC_LSB = 8;
   localparam int POST_LSB = 6;
   localparam int PRE_LSB = 0;
   // values after reset
   localparam logic [2:0] FRC_SEL_RST = 3'h0;
   localparam logic [1:0] POST_SEL_RST = 2'h1;
   localparam logic [4:0] PRE_SEL_RST = 5'h00;
   localparam logic [8:0] FB_SEL_RST = 9'h030;
   // status field positions
   localparam int ST_MODE_LSB = 0;
   localparam int ST_POSC_LSB = 3;
   localparam int ST_LOCK_BIT = 5;
   // erased config word reads all ones
   localparam logic [2:0] CFG_ERASED_MODE = 3'h7;
   localparam logic [1:0] CFG_ERASED_POSC = 2'h3;
   localparam logic [1:0] POSC_OFF = 2'h3;
   // frc divide by 16 mode
   localparam logic [8:0] FRC16_DIV = 9'h010;
   // input edges the pll needs to settle
   localparam logic [7:0] PLL_LOCK_EDGES = 8'h40;
   // credit ceiling of the pll rate model
   localparam logic [15:0] PLL_CREDIT_MAX = 16'hf000;

   // initial oscillator modes
   typedef enum logic [2:0] {
      MODE_FRC = 3'h0,
      MODE_FRC_PLL = 3'h1,
      MODE_PRI = 3'h2,
      MODE_PRI_PLL = 3'h3,
      MODE_SEC = 3'h4,
      MODE_LOW_POWER_INTERNAL_RC = 3'h5,
      MODE_FRC16 = 3'h6,
      MODE_FRCN = 3'h7
   } ocs_mode_t;

   // one-hot control states
   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_SETTLE = 3'b010,
      ST_RUN = 3'b100
   } ocs_state_t;

   // frc postscale divisor
   function automatic logic [8:0] frc_div(input logic [2:0] code);
      frc_div = (code == 3'h7) ? 9'h100 : (9'h001 << code);
   endfunction

   // pll postscale divisor, reserved code taken as 4
   function automatic logic [3:0] post_div(input logic [1:0] code);
      post_div = (code == 2'h0) ? 4'h2 : ((code == 2'h3) ? 4'h8 : 4'h4);
   endfunction

   // mode routes through the pll
   function automatic logic is_pll(input ocs_mode_t m);
      is_pll = (m == MODE_FRC_PLL) || (m == MODE_PRI_PLL);
   endfunction
endpackage

// file: ocs_pll.sv
`timescale 1ns/100ps
// ----------------------------------------
// pll rate model: fosc = fin*m/(n1*n2)
// ----------------------------------------
module ocs_pll (
   input wire logic core_clk,
   input wire logic arst_n,
   ocs_pll_if.pll lnk
);
   typedef struct packed {
      logic [15:0] credit; // owed output cycles, scaled
      logic [7:0] lock_cnt; // input edges since change
      logic [15:0] cfg; // last seen divider setting
      logic tick;
      logic locked;
   } ocs_pll_st_t;

   ocs_pll_st_t s_reg;
   ocs_pll_st_t s_next;
   logic [5:0] n1;
   logic [9:0] m;
   logic [8:0] den;
   logic [15:0] cfg_now;

   // factor decode
   always_comb begin
      n1 = {1'b0, lnk.pre_sel} + 6'h02; // [R5] [R9]
      m = {1'b0, lnk.fb_sel} + 10'h002; // [R6] [R10]
      // widen both factors first: 33*8 does not fit in six bits
      den = {3'h0, n1} * {5'h00, ocs_pkg::post_div(lnk.post_sel)}; // [R7] [R11]
      cfg_now = {lnk.post_sel, lnk.pre_sel, lnk.fb_sel};
   end

   // credit accumulator and settle counter
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      s_next.cfg = cfg_now;
      if (!lnk.enable || cfg_now != s_reg.cfg) begin
         // restart settling on any change
         s_next.credit = 16'h0000;
         s_next.lock_cnt = 8'h00;
         s_next.locked = 1'b0;
      end else begin
         // each input edge owes m output cycles
         if (lnk.fin_rise && s_reg.credit < ocs_pkg::PLL_CREDIT_MAX) begin
            s_next.credit = s_reg.credit + {6'h00, m}; // [R8]
         end
         if (s_next.credit >= {7'h00, den}) begin
            s_next.credit = s_next.credit - {7'h00, den}; // [R8]
            s_next.tick = s_reg.locked; // [R20]
         end
         if (lnk.fin_rise && !s_reg.locked) begin
            s_next.lock_cnt = s_reg.lock_cnt + 8'h01;
         end
         s_next.locked = s_reg.locked || (s_reg.lock_cnt >= ocs_pkg::PLL_LOCK_EDGES); // [R20]
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lnk.fosc_tick = s_reg.tick;
   assign lnk.locked = s_reg.locked;
endmodule // ocs_pll

// file: ocs_pll_if.sv
`timescale 1ns/100ps
// ----------------------------------------
// control to pll model link
// ----------------------------------------
interface ocs_pll_if;
   logic fin_rise; // one pll input edge
   logic enable; // pll path in use
   logic [4:0] pre_sel;
   logic [8:0] fb_sel;
   logic [1:0] post_sel;
   logic fosc_tick; // one pll output cycle
   logic locked; // settled, output live
   modport ctrl (output fin_rise, enable, pre_sel, fb_sel, post_sel, input fosc_tick, locked);
   modport pll (input fin_rise, enable, pre_sel, fb_sel, post_sel, output fosc_tick, locked);
endinterface

// file: ocs_top.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// R1: frc postscale from 1:1 up to 1:256
// R2: reset mode from select and primary fields
// R3: erased fields start from fast rc
// R4: instruction clock is oscillator clock halved
// R5: pll prescale 2 to 33 from low field
// R6: nine-bit feedback field sets multiplier
// R7: postscale 2, 4 or 8, bits 7:6
// R8: output equals fin times m over n1*n2
// R9: prescale factor is field plus two
// R10: multiplier is field plus two
// R11: postscale code zero divides by two
// R12: software keeps vco input 0.8-8 mhz
// R13: software keeps vco output 100-200 mhz
// R14: software keeps pll output 12.5-80 mhz
// R15: low-power rc feeds watchdog and monitor; the code drives only wdt_ref_clk and has no clock monitor
// R16: only frc and primary feed pll
// R17: seven system clock options offered
// R18: select field decodes eight modes
// R19: frc postscale codes 1..64, then 256
// R20: pll output held until settled
module ocs_top (
   input wire logic core_clk,
   input wire logic arst_n,
   // oscillator sources, sampled levels
   input wire logic fast_internal_rc,
   input wire logic primary_osc_in,
   input wire logic secondary_osc_in,
   input wire logic low_power_internal_rc,
   // configuration word fields
   input wire logic [2:0] initial_osc_select,
   input wire logic [1:0] primary_osc_mode_sel,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // clock outputs as enable pulses, watchdog reference as a registered level, then mode and lock
   output logic osc_tick,
   output logic instr_tick,
   output logic wdt_ref_clk,
   output logic [2:0] osc_mode,
   output logic pll_lock
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ocs_pkg::ocs_state_t st; // control state
      logic [2:0] mode; // latched oscillator mode
      logic [1:0] posc; // latched primary mode
      logic [3:0] src_prev; // last source levels
      logic [2:0] frc_sel; // frc postscale code
      logic [1:0] post_sel; // pll postscale code
      logic [4:0] pre_sel; // pll prescale code
      logic [8:0] fb_sel; // pll feedback code
      logic [7:0] frc_cnt; // frc postscale count
      logic half; // instruction clock phase
      logic osc_tick; // registered fosc pulse
      logic instr_tick; // registered fcy pulse
      logic low_power_internal_rc_ref; // watchdog reference copy
      logic lock; // registered lock flag
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ocs_top_st_t;

   ocs_top_st_t s_reg;
   ocs_top_st_t s_next;

   // ----------------------------------------
   // combinational helpers
   // ----------------------------------------
   logic [3:0] src_now; // current source levels
   logic [3:0] rise; // rising edges per source
   logic posc_en; // primary oscillator enabled
   logic [8:0] frc_divisor; // active frc divisor
   logic frc_tick; // postscaled frc edge
   logic sel_tick; // selected oscillator edge
   logic apb_setup; // setup phase seen
   logic apb_write; // write takes effect now
   logic addr_ok; // mapped address
   logic [31:0] rd_word; // read mux result
   ocs_pkg::ocs_mode_t cur_mode;

   ocs_pll_if pll_lnk ();

   ocs_pll u_pll (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .lnk(pll_lnk.pll)
   );

   // edge detect on all four sources
   always_comb begin
      src_now = {low_power_internal_rc, secondary_osc_in, primary_osc_in, fast_internal_rc};
      rise = src_now & ~s_reg.src_prev;
      cur_mode = ocs_pkg::ocs_mode_t'(s_reg.mode);
      // primary mode 11 means primary is off
      posc_en = (s_reg.posc != ocs_pkg::POSC_OFF);
   end

   // pll link drive, primary or frc only
   always_comb begin
      pll_lnk.enable = (s_reg.st != ocs_pkg::ST_STRAP) && ocs_pkg::is_pll(cur_mode);
      pll_lnk.fin_rise = (cur_mode == ocs_pkg::MODE_PRI_PLL) ? (rise[1] && posc_en) : rise[0]; // [R16]
      pll_lnk.pre_sel = s_reg.pre_sel;
      pll_lnk.fb_sel = s_reg.fb_sel;
      pll_lnk.post_sel = s_reg.post_sel;
   end

   // frc postscaler divisor pick
   always_comb begin
      if (cur_mode == ocs_pkg::MODE_FRC16) begin
         frc_divisor = ocs_pkg::FRC16_DIV; // [R18]
      end else begin
         frc_divisor = ocs_pkg::frc_div(s_reg.frc_sel); // [R1] [R19]
      end
      // a tick on the last frc edge of the group
      frc_tick = rise[0] && ({1'b0, s_reg.frc_cnt} == frc_divisor - 9'h001);
   end

   // ----------------------------------------
   // system clock source mux
   // ----------------------------------------
   // seven options; frc16 and frcn share a path
   always_comb begin
      unique case (cur_mode) // [R17] [R18]
         ocs_pkg::MODE_FRC: begin
            sel_tick = rise[0];
         end
         ocs_pkg::MODE_FRC_PLL, ocs_pkg::MODE_PRI_PLL: begin
            sel_tick = pll_lnk.fosc_tick; // [R20]
         end
         ocs_pkg::MODE_PRI: begin
            sel_tick = rise[1] && posc_en;
         end
         ocs_pkg::MODE_SEC: begin
            sel_tick = rise[2];
         end
         ocs_pkg::MODE_LOW_POWER_INTERNAL_RC: begin
            sel_tick = rise[3];
         end
         ocs_pkg::MODE_FRC16, ocs_pkg::MODE_FRCN: begin
            sel_tick = frc_tick;
         end
      endcase
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   always_comb begin
      apb_setup = psel && !penable;
      // pready is high in every access phase
      apb_write = psel && penable && pwrite && s_reg.pready;
      addr_ok = (paddr == ocs_pkg::OFS_CLOCK_DIVISOR_REG) || (paddr == ocs_pkg::OFS_PLL_FEEDBACK_REG) || (paddr == ocs_pkg::OFS_STATUS);
      rd_word = 32'h0000_0000;
      unique case (paddr)
         ocs_pkg::OFS_CLOCK_DIVISOR_REG: begin
            rd_word[ocs_pkg::FRC_LSB +: 3] = s_reg.frc_sel;
            rd_word[ocs_pkg::POST_LSB +: 2] = s_reg.post_sel;
            rd_word[ocs_pkg::PRE_LSB +: 5] = s_reg.pre_sel;
         end
         ocs_pkg::OFS_PLL_FEEDBACK_REG: begin
            rd_word[8:0] = s_reg.fb_sel;
         end
         ocs_pkg::OFS_STATUS: begin
            // live mode and lock, read only
            rd_word[ocs_pkg::ST_MODE_LSB +: 3] = s_reg.mode;
            rd_word[ocs_pkg::ST_POSC_LSB +: 2] = s_reg.posc;
            rd_word[ocs_pkg::ST_LOCK_BIT] = s_reg.lock;
         end
         default: begin
            rd_word = 32'h0000_0000; // unmapped reads zero
         end
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.src_prev = src_now;
      s_next.osc_tick = 1'b0;
      s_next.instr_tick = 1'b0;
      s_next.lock = pll_lnk.locked;
      // watchdog reference runs in every mode
      s_next.low_power_internal_rc_ref = low_power_internal_rc; // [R15]

      // control sequence after reset release
      unique case (s_reg.st)
         ocs_pkg::ST_STRAP: begin
            // config word caught once, after release
            s_next.mode = initial_osc_select; // [R2]
            s_next.posc = primary_osc_mode_sel; // [R2]
            // erased word is 111: frc through postscaler
            s_next.st = ocs_pkg::ST_SETTLE; // [R3]
         end
         ocs_pkg::ST_SETTLE: begin
            // non pll modes are live at once
            if (!ocs_pkg::is_pll(cur_mode) || pll_lnk.locked) begin
               s_next.st = ocs_pkg::ST_RUN; // [R20]
            end
         end
         ocs_pkg::ST_RUN: begin
            // a divider rewrite drops lock: hold again
            if (ocs_pkg::is_pll(cur_mode) && !pll_lnk.locked) begin
               s_next.st = ocs_pkg::ST_SETTLE; // [R20]
            end
         end
         default: begin
            s_next.st = ocs_pkg::ST_STRAP; // illegal code recovers
         end
      endcase

      // frc postscale counter, free running
      if (rise[0]) begin
         s_next.frc_cnt = frc_tick ? 8'h00 : s_reg.frc_cnt + 8'h01; // [R19]
      end

      // fosc and fcy pulses only once running
      if (s_reg.st == ocs_pkg::ST_RUN && sel_tick) begin
         s_next.osc_tick = 1'b1;
         s_next.half = !s_reg.half;
         s_next.instr_tick = s_reg.half; // [R4]
      end

      // apb answer registered in setup phase
      s_next.pready = apb_setup;
      s_next.pslverr = apb_setup && !addr_ok;
      if (apb_setup) begin
         s_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
      end

      // register writes, status is read only
      if (apb_write) begin
         if (paddr == ocs_pkg::OFS_CLOCK_DIVISOR_REG) begin
            s_next.frc_sel = pwdata[ocs_pkg::FRC_LSB +: 3]; // [R1]
            s_next.post_sel = pwdata[ocs_pkg::POST_LSB +: 2]; // [R7]
            s_next.pre_sel = pwdata[ocs_pkg::PRE_LSB +: 5]; // [R5]
         end
         if (paddr == ocs_pkg::OFS_PLL_FEEDBACK_REG) begin
            s_next.fb_sel = pwdata[8:0]; // [R6]
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.st <= ocs_pkg::ST_STRAP;
         s_reg.mode <= ocs_pkg::CFG_ERASED_MODE;
         s_reg.posc <= ocs_pkg::CFG_ERASED_POSC;
         s_reg.frc_sel <= ocs_pkg::FRC_SEL_RST;
         s_reg.post_sel <= ocs_pkg::POST_SEL_RST;
         s_reg.pre_sel <= ocs_pkg::PRE_SEL_RST;
         s_reg.fb_sel <= ocs_pkg::FB_SEL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   always_comb begin
      prdata = s_reg.prdata;
      pready = s_reg.pready;
      pslverr = s_reg.pslverr;
      osc_tick = s_reg.osc_tick;
      instr_tick = s_reg.instr_tick;
      wdt_ref_clk = s_reg.low_power_internal_rc_ref;
      osc_mode = s_reg.mode;
      pll_lock = s_reg.lock;
   end
endmodule // ocs_top

// file: tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// clock select testbench
// ----------------------------------------
module tb_top;
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic fast_internal_rc, primary_osc_in, secondary_osc_in, low_power_internal_rc;
   logic [2:0] initial_osc_select;
   logic [1:0] primary_osc_mode_sel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic osc_tick, instr_tick, wdt_ref_clk, pll_lock;
   logic [2:0] osc_mode;
   int n_fail, n_tests, cyc;
   ocs_osc_src src (.fast_internal_rc, .primary_osc_in, .secondary_osc_in, .low_power_internal_rc);
   ocs_top dut (.core_clk, .arst_n, .fast_internal_rc, .primary_osc_in, .secondary_osc_in,
      .low_power_internal_rc, .initial_osc_select, .primary_osc_mode_sel, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_tick, .instr_tick, .wdt_ref_clk, .osc_mode,
      .pll_lock);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic print_verdict;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // hang guard, well above the expected run length
   initial begin
      cyc = 0;
      forever begin
         @(posedge core_clk);
         cyc++;
         if (cyc == 90000) begin
            n_fail++;
            print_verdict();
         end
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // rate counts drift by the window phase, so allow a margin
   task automatic near(input string what, input int seen, input int exp);
      int tol;
      tol = 2 + exp / 100;
      check(what, (seen >= exp - tol && seen <= exp + tol) ? exp : seen, exp);
   endtask
   // one apb transfer, held until ready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      // pready, prdata and pslverr are taken at the rising edge itself
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(what, rd, exp);
      check("slave error", {31'h0, err}, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic do_reset(input logic [2:0] m, input logic [1:0] p);
      arst_n <= 1'b0;
      initial_osc_select <= m;
      primary_osc_mode_sel <= p;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
   // ticks are one cycle wide, so sample once per cycle after the edge
   task automatic count(input int n, output int no, output int ni);
      no = 0;
      ni = 0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         no += osc_tick;
         ni += instr_tick;
      end
   endtask
   task automatic t_regs;
      do_reset(3'h7, 2'h3);
      check("erased mode", {29'h0, osc_mode}, 32'h7);
      rd_chk("status", 8'h08, 32'h1f, 1'b0);
      rd_chk("divisor reset", 8'h00, 32'h40, 1'b0);
      rd_chk("feedback reset", 8'h04, 32'h30, 1'b0);
      wr(8'h00, 32'hffffffff);
      rd_chk("divisor mask", 8'h00, 32'h7df, 1'b0);
      wr(8'h04, 32'hffffffff);
      rd_chk("feedback mask", 8'h04, 32'h1ff, 1'b0);
      wr(8'h08, 32'h0);
      rd_chk("status ro", 8'h08, 32'h1f, 1'b0);
      rd_chk("unmapped", 8'h0c, 32'h0, 1'b1);
   endtask
   task automatic t_modes;
      int ex[8] = '{200, 1250, 143, 893, 67, 40, 13, 200};
      int no, ni;
      for (int m = 0; m < 8; m++) begin
         do_reset(m[2:0], 2'h0);
         check("mode", {29'h0, osc_mode}, m);
         repeat (1000) @(posedge core_clk);
         count(2000, no, ni);
         near("osc rate", no, ex[m]);
         near("instr rate", ni, no / 2);
      end
      do_reset(3'h2, 2'h3);
      count(500, no, ni);
      check("primary off", no, 0);
   endtask
   task automatic t_fast_rc_postscale_sel;
      int no, ni;
      do_reset(3'h7, 2'h0);
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, {21'h0, c[2:0], 8'h40});
         repeat (20) @(posedge core_clk);
         count(2560, no, ni);
         near("frc postscale", no, 256 / ((c == 7) ? 256 : (1 << c)));
      end
   endtask
   task automatic t_pll;
      int no, ni, k;
      // software side picks the divider settings
      logic [4:0] pre[5] = '{5'h00, 5'h01, 5'h1f, 5'h00, 5'h1f};
      logic [1:0] post[5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3};
      logic [8:0] fb[5] = '{9'h01e, 9'h01e, 9'h01e, 9'h006, 9'h100};
      int ex[5] = '{800, 267, 12, 100, 98};
      do_reset(3'h1, 2'h0);
      for (int i = 0; i < 5; i++) begin
         wr(8'h04, {23'h0, fb[i]});
         wr(8'h00, {24'h0, post[i], 1'b0, pre[i]});
         // lock flag trails the divider change by two registers
         repeat (2) @(posedge core_clk);
         rd_chk("lock after write", 8'h08, 32'h01, 1'b0);
         k = 0;
         while (pll_lock !== 1'b1 && k < 3000) begin
            @(posedge core_clk);
            k++;
         end
         count(1000, no, ni);
         near("pll rate", no, ex[i]);
      end
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      initial_osc_select = 3'h7;
      primary_osc_mode_sel = 2'h3;
      t_regs();
      t_modes();
      t_fast_rc_postscale_sel();
      t_pll();
      print_verdict();
   end
endmodule // tb_top
bind ocs_top ocs_chk chk (.core_clk, .arst_n, .fast_internal_rc, .low_power_internal_rc, .psel, .penable,
   .paddr, .pready, .pslverr, .osc_tick, .instr_tick, .wdt_ref_clk, .osc_mode, .pll_lock);
